// file: rtl/tts_filter.sv
`include "tts_params.svh"

module tts_filter (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Filter link
	tts_filter_if.filt link
);
	import tts_pkg::*;

	tts_cnt_t div_cnt;
	tts_cnt_t next_div_cnt;
	tts_cnt_t agree_cnt;
	tts_cnt_t next_agree_cnt;
	logic level;
	logic next_level;
	tts_cnt_t div_last;
	tts_cnt_t need;
	logic tick;

	// Selects sampling divider and sample count.
	always_comb begin
		case (link.code)
			`TTS_FLT_16_8: begin
				div_last = `TTS_DIV_16 - `TTS_DIV_1;
				need = `TTS_N_8;
			end
			`TTS_FLT_32_6: begin
				div_last = `TTS_DIV_32 - `TTS_DIV_1;
				need = `TTS_N_6;
			end
			`TTS_FLT_32_8: begin
				div_last = `TTS_DIV_32 - `TTS_DIV_1;
				need = `TTS_N_8;
			end
			default: begin
				div_last = `TTS_DIV_1 - `TTS_DIV_1;
				need = `TTS_N_1;
			end
		endcase
	end

	assign tick = (div_cnt >= div_last);

	// Output changes only after enough agreeing samples.
	always_comb begin
		next_div_cnt = tick ? `TTS_CNT_RST : div_cnt + `TTS_DIV_1;
		next_agree_cnt = agree_cnt;
		next_level = level;
		if (tick) begin
			if (link.sample_in != level) begin
				if (agree_cnt + `TTS_N_1 >= need) begin
					next_level = link.sample_in;
					next_agree_cnt = `TTS_CNT_RST;
				end else begin
					next_agree_cnt = agree_cnt + `TTS_N_1;
				end
			end else begin
				next_agree_cnt = `TTS_CNT_RST;
			end
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			div_cnt <= `TTS_CNT_RST;
			agree_cnt <= `TTS_CNT_RST;
			level <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			agree_cnt <= next_agree_cnt;
			level <= next_level;
		end
	end

	assign link.filtered = level;

	a_flt_div16_n8: assert property (@(posedge clock_i) disable iff (reset_i)
		(link.code == `TTS_FLT_16_8 && $past(link.code) == `TTS_FLT_16_8 && level != $past(level))
		|-> ($past(agree_cnt) == 6'h07 && $past(div_cnt) == 6'h0F))
		else $error("Filter 1100 changed without eight samples at div 16.");

	a_flt_div32_n6: assert property (@(posedge clock_i) disable iff (reset_i)
		(link.code == `TTS_FLT_32_6 && $past(link.code) == `TTS_FLT_32_6 && level != $past(level))
		|-> ($past(agree_cnt) == 6'h05 && $past(div_cnt) == 6'h1F))
		else $error("Filter 1110 changed without six samples at div 32.");

	a_flt_div32_n8: assert property (@(posedge clock_i) disable iff (reset_i)
		(link.code == `TTS_FLT_32_8 && $past(link.code) == `TTS_FLT_32_8 && level != $past(level))
		|-> ($past(agree_cnt) == 6'h07 && $past(div_cnt) == 6'h1F))
		else $error("Filter 1111 changed without eight samples at div 32.");

	a_flt_hold_level: assert property (@(posedge clock_i) disable iff (reset_i)
		(tick && link.sample_in == level) |=> ($stable(level) && agree_cnt == 6'h00))
		else $error("Filter output moved on an agreeing sample.");

endmodule // tts_filter

// file: rtl/tts_filter_if.sv
interface tts_filter_if;
	import tts_pkg::*;
	tts_flt_t code;
	logic sample_in;
	logic filtered;
	modport filt (
		input code,
		input sample_in,
		output filtered
	);
	modport user (
		output code,
		output sample_in,
		input filtered
	);
endinterface

// file: rtl/tts_params.svh
`ifndef TTS_PARAMS_SVH
`define TTS_PARAMS_SVH

// Filter setting codes.
`define TTS_FLT_16_8 4'hC
`define TTS_FLT_32_6 4'hE
`define TTS_FLT_32_8 4'hF

// Sampling dividers of the filter base clock.
`define TTS_DIV_1 6'h01
`define TTS_DIV_16 6'h10
`define TTS_DIV_32 6'h20

// Consecutive agreeing samples needed.
`define TTS_N_1 6'h01
`define TTS_N_6 6'h06
`define TTS_N_8 6'h08

// Reset values.
`define TTS_SRC_RST 3'h0
`define TTS_CNT_RST 6'h00

`endif

// file: rtl/tts_pkg.sv
package tts_pkg;
	typedef logic [2:0] tts_src_t;
	typedef logic [3:0] tts_flt_t;
	typedef logic [5:0] tts_cnt_t;
	typedef enum logic [2:0] {
		TTS_SRC_INTERNAL_TRIGGER_ZERO = 3'h0,
		TTS_SRC_TI1_ED = 3'h4,
		TTS_SRC_TI1_FP = 3'h5,
		TTS_SRC_TI2_FP = 3'h6,
		TTS_SRC_ETR = 3'h7
	} tts_src_e;
endpackage

// file: rtl/tts_trigger_sel.sv
`include "tts_params.svh"

module tts_trigger_sel (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Trigger sources
	input wire logic internal_trigger_zero_i,
	input wire logic input_one_edge_detect_i,
	input wire logic filtered_input_one_i,
	input wire logic filtered_input_two_i,
	input wire logic ext_trigger_i,
	// Configuration
	input wire tts_pkg::tts_src_t trigger_source_sel_i,
	input wire tts_pkg::tts_src_t slave_mode_sel_i,
	input wire logic master_slave_sync_i,
	input wire tts_pkg::tts_flt_t ext_filter_sel_i,
	// Trigger outputs
	output logic filtered_external_trigger_o,
	output logic trigger_in_o,
	output logic trigger_out_o,
	output logic trigger_event_o
);
	import tts_pkg::*;

	logic ext_meta;
	logic ext_sync;
	tts_src_t active_src;
	tts_src_t next_active_src;
	logic src_level;
	logic trig_level;
	logic rise;
	logic held_rise;
	logic next_trigger_out;
	logic next_trigger_event;
	logic next_ext_meta;
	logic next_ext_sync;
	logic next_trig_level;
	logic next_held_rise;
	logic next_trigger_in;

	tts_filter_if link ();

	// Next values of the two-stage pin synchroniser.
	always_comb begin
		next_ext_meta = ext_trigger_i;
		next_ext_sync = ext_meta;
	end

	// Brings the external pin into the clock domain.
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
		end else begin
			ext_meta <= next_ext_meta;
			ext_sync <= next_ext_sync;
		end
	end

	assign link.code = ext_filter_sel_i;
	assign link.sample_in = ext_sync;

	tts_filter u_filter (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.link(link)
	);

	assign filtered_external_trigger_o = link.filtered;

	// Source is latched only while slave mode is off.
	always_comb begin
		next_active_src = active_src;
		if (slave_mode_sel_i == `TTS_SRC_RST) begin
			next_active_src = trigger_source_sel_i;
		end
	end

	// Picks the synchronising trigger.
	always_comb begin
		case (active_src)
			TTS_SRC_INTERNAL_TRIGGER_ZERO: begin
				src_level = internal_trigger_zero_i;
			end
			TTS_SRC_TI1_ED: begin
				src_level = input_one_edge_detect_i;
			end
			TTS_SRC_TI1_FP: begin
				src_level = filtered_input_one_i;
			end
			TTS_SRC_TI2_FP: begin
				src_level = filtered_input_two_i;
			end
			TTS_SRC_ETR: begin
				src_level = link.filtered;
			end
			default: begin
				src_level = 1'b0;
			end
		endcase
	end

	assign rise = src_level & ~trig_level;

	// With master_slave_sync_i set, the own event waits one cycle so slaves act with it.
	always_comb begin
		next_trigger_out = rise;
		next_trigger_event = master_slave_sync_i ? held_rise : rise;
		next_trig_level = src_level;
		next_held_rise = rise;
		next_trigger_in = src_level;
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			active_src <= `TTS_SRC_RST;
			trig_level <= 1'b0;
			held_rise <= 1'b0;
			trigger_in_o <= 1'b0;
			trigger_out_o <= 1'b0;
			trigger_event_o <= 1'b0;
		end else begin
			active_src <= next_active_src;
			trig_level <= next_trig_level;
			held_rise <= next_held_rise;
			trigger_in_o <= next_trigger_in;
			trigger_out_o <= next_trigger_out;
			trigger_event_o <= next_trigger_event;
		end
	end

	a_msm_delayed_event: assert property (@(posedge clock_i) disable iff (reset_i)
		(trigger_out_o && master_slave_sync_i) |=> trigger_event_o)
		else $error("Delayed trigger event missing one cycle after trigger out.");

	a_msm_no_early: assert property (@(posedge clock_i) disable iff (reset_i)
		(rise && master_slave_sync_i && !held_rise) |=> !trigger_event_o)
		else $error("Trigger event not delayed with sync bit set.");

	a_msm_off_direct: assert property (@(posedge clock_i) disable iff (reset_i)
		(rise && !master_slave_sync_i) |=> (trigger_event_o && trigger_out_o))
		else $error("Trigger event delayed with sync bit clear.");

	a_src_internal_trigger_zero_path: assert property (@(posedge clock_i) disable iff (reset_i)
		(active_src == TTS_SRC_INTERNAL_TRIGGER_ZERO) |=> (trigger_in_o == $past(internal_trigger_zero_i)))
		else $error("Internal trigger zero not routed.");

	a_src_etr_path: assert property (@(posedge clock_i) disable iff (reset_i)
		(active_src == TTS_SRC_ETR) |=> (trigger_in_o == $past(link.filtered)))
		else $error("Filtered external trigger not routed.");

	a_src_ti2_path: assert property (@(posedge clock_i) disable iff (reset_i)
		(active_src == TTS_SRC_TI2_FP) |=> (trigger_in_o == $past(filtered_input_two_i)))
		else $error("Filtered input two not routed.");

	// Source latch and routing checks.
	a_src_latch_open: assert property (@(posedge clock_i) disable iff (reset_i)
		(slave_mode_sel_i == 3'h0) |=> (active_src == $past(trigger_source_sel_i)))
		else $error("Source select not taken with slave mode off.");

	a_src_latch_frozen: assert property (@(posedge clock_i) disable iff (reset_i)
		(slave_mode_sel_i != 3'h0) |=> $stable(active_src))
		else $error("Source changed while slave mode on.");

	a_src_ed_path: assert property (@(posedge clock_i) disable iff (reset_i)
		(active_src == TTS_SRC_TI1_ED) |=> (trigger_in_o == $past(input_one_edge_detect_i)))
		else $error("Input one edge detect not routed.");

	a_src_ti1_path: assert property (@(posedge clock_i) disable iff (reset_i)
		(active_src == TTS_SRC_TI1_FP) |=> (trigger_in_o == $past(filtered_input_one_i)))
		else $error("Filtered input one not routed.");

	a_src_unused_low: assert property (@(posedge clock_i) disable iff (reset_i)
		(active_src == 3'h1 || active_src == 3'h2 || active_src == 3'h3) |=> !trigger_in_o)
		else $error("Unused source code did not give a low trigger.");

	a_ext_sync_path: assert property (@(posedge clock_i) disable iff (reset_i)
		(!$past(reset_i) && !$past(reset_i, 2)) |-> (ext_sync == $past(ext_trigger_i, 2)))
		else $error("External pin not passed through two flip-flops.");

	// Trigger pulse checks.
	a_out_on_rise: assert property (@(posedge clock_i) disable iff (reset_i)
		trigger_out_o == (trigger_in_o && !$past(trigger_in_o)))
		else $error("Trigger out not a rising edge of the selected source.");

	a_out_one_cycle: assert property (@(posedge clock_i) disable iff (reset_i)
		trigger_out_o |=> !trigger_out_o)
		else $error("Trigger out longer than one cycle.");

	a_msm_off_none: assert property (@(posedge clock_i) disable iff (reset_i)
		(!rise && !master_slave_sync_i) |=> !trigger_event_o)
		else $error("Late trigger event with sync bit clear.");

	a_msm_on_late: assert property (@(posedge clock_i) disable iff (reset_i)
		(rise && master_slave_sync_i) ##1 master_slave_sync_i |=> trigger_event_o)
		else $error("Delayed trigger event missing with sync bit set.");

endmodule // tts_trigger_sel

// file: verification/tts_master_model.sv
module tts_master_model (
	// Clock, reset and request
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic fire_i,
	// Trigger link to the slave timer
	output logic trigger_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// A master timer drives a registered one-cycle trigger output.
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			trigger_o <= 1'h0;
		end else begin
			trigger_o <= fire_i;
		end
	end
endmodule // tts_master_model

// file: verification/tts_trigger_sel_bench.sv
module tts_trigger_sel_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import tts_pkg::*;
	logic clock_i = 1'h0;
	logic reset_i = 1'h1;
	logic fire = 1'h0;
	logic internal_trigger_zero;
	logic ed = 1'h0;
	logic f1 = 1'h0;
	logic f2 = 1'h0;
	logic ext = 1'h0;
	logic sync = 1'h0;
	tts_src_t src = 3'h0;
	tts_src_t slave_mode_sel = 3'h0;
	tts_flt_t flt = 4'h0;
	logic etf;
	logic tin;
	logic tout;
	logic tev;
	int n_fail = 0;
	int n_checks = 0;
	always #5 clock_i = ~clock_i;
	tts_master_model i_tts_master_model (.clock_i(clock_i), .reset_i(reset_i), .fire_i(fire),
		.trigger_o(internal_trigger_zero));
	tts_trigger_sel i_tts_trigger_sel (.clock_i(clock_i), .reset_i(reset_i),
		.internal_trigger_zero_i(internal_trigger_zero), .input_one_edge_detect_i(ed),
		.filtered_input_one_i(f1), .filtered_input_two_i(f2), .ext_trigger_i(ext),
		.trigger_source_sel_i(src), .slave_mode_sel_i(slave_mode_sel), .master_slave_sync_i(sync),
		.ext_filter_sel_i(flt), .filtered_external_trigger_o(etf), .trigger_in_o(tin),
		.trigger_out_o(tout), .trigger_event_o(tev));
	task automatic chk(input logic exp, input logic got, input string what);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s: got %b expected %b", $time, what, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic pulse(input logic s);
		@(posedge clock_i) sync <= s;
		fire <= 1'h1;
		@(posedge clock_i) fire <= 1'h0;
		@(posedge clock_i);
		@(negedge clock_i);
		chk(1'h1, tout, "trigger out");
		chk(~s, tev, "event undelayed");
		@(negedge clock_i);
		chk(1'h0, tout, "trigger out end");
		chk(s, tev, "event delayed");
	endtask
	task automatic pick(input tts_src_t s, input tts_src_t m, input logic [2:0] lv);
		@(posedge clock_i) src <= s;
		slave_mode_sel <= m;
		{f2, f1, ed} <= lv;
		repeat (3) @(negedge clock_i);
	endtask
	task automatic filt(input tts_flt_t c, input int div, input int n);
		int t;
		@(posedge clock_i) flt <= c;
		if (n > 2) begin
			@(posedge clock_i) ext <= 1'h1;
			repeat (div * (n - 2)) @(posedge clock_i);
			ext <= 1'h0;
			repeat (div * n + 8) @(negedge clock_i);
			chk(1'h0, etf, "short pulse held off");
		end
		for (int e = 1; e >= 0; e--) begin
			@(posedge clock_i) ext <= e[0];
			t = 0;
			while (etf !== e[0] && t < 400) begin
				@(negedge clock_i);
				t++;
			end
			chk(1'h1, t >= (n - 1) * div && t <= n * div + 6, "filter latency");
			if (t >= 400)
				summarize();
			@(negedge clock_i);
			chk(e[0], tin, "external source");
		end
		$display("filter test code %h done", c);
	endtask
	initial begin
		repeat (8) @(posedge clock_i);
		reset_i <= 1'h0;
		@(negedge clock_i);
		chk(1'h0, tout | tev | tin | etf, "reset outputs");
		pulse(1'h0);
		pulse(1'h1);
		$display("sync test done");
		pick(3'h2, 3'h0, 3'h7);
		chk(1'h0, tin, "unused source low");
		for (int k = 0; k < 3; k++) begin
			pick(3'h4 + 3'(k), 3'h0, 3'h1 << k);
			chk(1'h1, tin, "selected high");
			pick(3'h4 + 3'(k), 3'h0, ~(3'h1 << k));
			chk(1'h0, tin, "selected low");
		end
		pick(3'h4, 3'h1, 3'h1);
		chk(1'h0, tin, "source frozen");
		pick(3'h4, 3'h0, 3'h1);
		chk(1'h1, tin, "source taken");
		pick(3'h7, 3'h0, 3'h0);
		$display("select test done");
		filt(4'h0, 1, 1);
		filt(4'hC, 16, 8);
		filt(4'hE, 32, 6);
		filt(4'hF, 32, 8);
		summarize();
	end
endmodule // tts_trigger_sel_bench
